// ### logic/vps_defines.svh
// Register offsets, control field width, reset values and limits of the sequencer
`ifndef VPS_DEFINES_SVH
`define VPS_DEFINES_SVH

// ********************************************
// Register byte offsets on the APB slave
// ********************************************
`define VPS_OFS_CTRL 8'h00
`define VPS_OFS_CLKF 8'h04
`define VPS_OFS_STRB 8'h08
`define VPS_OFS_INIT 8'h0C
`define VPS_OFS_MAIN 8'h10
`define VPS_OFS_WADR 8'h14
`define VPS_OFS_WDAT 8'h18
`define VPS_OFS_COND 8'h1C
`define VPS_OFS_STAT 8'h20

// ********************************************
// Control field width and reset values
// ********************************************
`define VPS_CTRL_W 5
`define VPS_CTRL_RST 5'h00
`define VPS_CLKF_RST 9'h064
`define VPS_STRB_RST 4'h0
`define VPS_COND_RST 32'h00000000

// ********************************************
// Clock limits in MHz and strobe delay in ns
// ********************************************
`define VPS_CLKF_MIN 9'h001
`define VPS_CLKF_MAX_FULL 9'h0B4
`define VPS_CLKF_MAX_HALF 9'h12C
`define VPS_STRB_MAX_NS 4'h8

// ********************************************
// Channel counts and storage depth
// ********************************************
`define VPS_HALF_CH 24
`define VPS_FULL_CH 48
`define VPS_DEPTH_FULL 8388608
`define VPS_ENTRY_W 28
`define VPS_NUM_COND 4
`define VPS_PAT_CODES 8

`endif

// ### logic/vps_pkg.sv
// Types shared by the vector pattern sequencer files
`default_nettype none
package vps_pkg;

   // Instruction carried by a stored vector
   typedef enum logic [1:0] {
      VPS_OP_NONE = 2'b00,
      VPS_OP_ARM = 2'b01,
      VPS_OP_WCOND = 2'b10,
      VPS_OP_WARM = 2'b11
   } vps_op_e;

   // Playback engine states
   typedef enum logic [1:0] {
      VPS_ST_IDLE = 2'b00,
      VPS_ST_INIT = 2'b01,
      VPS_ST_MAIN = 2'b10,
      VPS_ST_DONE = 2'b11
   } vps_state_e;

   // One storage entry: instruction, condition index, 24 lanes
   typedef struct packed {
      vps_op_e op;
      logic [1:0] cond;
      logic [23:0] data;
   } vps_entry_s;

   // Control register fields, run in bit 0
   typedef struct packed {
      logic chain;
      logic ext_clk;
      logic rep;
      logic half;
      logic run;
   } vps_ctrl_s;

   // Settings handed to the clock pod and clock generator
   typedef struct packed {
      logic [8:0] freq_mhz;
      logic [3:0] strobe_ns;
      logic ext_sel;
      logic chain;
   } vps_clkcfg_s;

endpackage
`default_nettype wire

// ### logic/vps_sequencer.sv
// Vector pattern sequencer: APB registers, vector store, playback engine
// Notes on behaviour
// - One vector out per rising output clock edge
// - Vector is a row of 1-32 bit fields
// - 48 channels full mode, 24 half mode
// - Eight million full, sixteen million half vectors
// - Clock capped 180 MHz full, 300 half
// - Five modules chain on one master time base
// - Modules may instead run on own clocks
// - Output clock source internal or external pod
// - Internal clock 1 to 300 MHz, 1 MHz steps
// - Strobe out delayed up to 8 ns
// - Init once, then main once, or repeats until stopped with rep set
// - Arm instruction raises arm to other modules
// - 3-bit input sensed by level, held stable
// - Four conditions, each OR of eight patterns
// - Wait may stall until arm arrives
// - Playback walks flat list in address order
`default_nettype none
`include "vps_defines.svh"
module vps_sequencer #(
   parameter int DEPTH = `VPS_DEPTH_FULL,
   parameter int AW = $clog2(2 * DEPTH)
) (
   // Register clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Output clock domain and target pins
   input wire logic link_clk_i,
   input wire logic [2:0] ext_pat_i,
   input wire logic arm_in_i,
   input wire logic chain_run_i,
   output logic [47:0] data_o,
   output logic arm_o,
   // Chain start and clock pod settings
   output logic chain_run_o,
   output var vps_pkg::vps_clkcfg_s clk_cfg_o
);
   import vps_pkg::*;

   localparam int LW = AW + 1;

   // ********************************************
   // Register domain state
   // ********************************************
   vps_ctrl_s ctrl_r;
   logic [8:0] freq_r;
   logic [3:0] strb_r;
   logic [LW-1:0] init_len_r;
   logic [LW-1:0] main_len_r;
   logic [AW-1:0] waddr_r;
   logic [31:0] cond_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   vps_clkcfg_s clk_cfg_r;
   logic chain_run_r;
   logic [2:0] stat_s;

   // Vector store, written only while stopped
   vps_entry_s mem [2*DEPTH];

   // ********************************************
   // APB decode
   // ********************************************
   wire logic acc;
   wire logic setup_ph;
   wire logic done;
   wire logic hit_ctrl;
   wire logic hit_clkf;
   wire logic hit_strb;
   wire logic hit_init;
   wire logic hit_main;
   wire logic hit_wadr;
   wire logic hit_wdat;
   wire logic hit_cond;
   wire logic hit_stat;
   wire logic mapped;
   wire logic locked;
   wire logic wr_ok;
   wire logic wr_cfg;

   // Phase of the current transfer
   assign acc = psel_i & penable_i;
   assign setup_ph = acc & ~pready_r;
   assign done = acc & pready_r;

   // Address match per register
   assign hit_ctrl = paddr_i == `VPS_OFS_CTRL;
   assign hit_clkf = paddr_i == `VPS_OFS_CLKF;
   assign hit_strb = paddr_i == `VPS_OFS_STRB;
   assign hit_init = paddr_i == `VPS_OFS_INIT;
   assign hit_main = paddr_i == `VPS_OFS_MAIN;
   assign hit_wadr = paddr_i == `VPS_OFS_WADR;
   assign hit_wdat = paddr_i == `VPS_OFS_WDAT;
   assign hit_cond = paddr_i == `VPS_OFS_COND;
   assign hit_stat = paddr_i == `VPS_OFS_STAT;
   assign mapped = hit_ctrl | hit_clkf | hit_strb | hit_init |
                   hit_main | hit_wadr | hit_wdat | hit_cond |
                   hit_stat;

   // Setup held steady while the engine runs
   assign locked = ctrl_r.run | stat_s[0];
   assign wr_ok = done & pwrite_i & mapped;
   assign wr_cfg = wr_ok & ~locked;

   // ********************************************
   // Write value shaping
   // ********************************************
   wire logic [8:0] freq_in;
   wire logic [8:0] freq_clamp;
   wire logic [8:0] fmax;
   wire logic [8:0] freq_eff;
   wire logic [3:0] strb_clamp;
   wire logic [4:0] ctrl_wr;

   // Frequency kept inside 1..300 MHz in 1 MHz steps
   assign freq_in = pwdata_i[8:0];
   assign freq_clamp = (freq_in < `VPS_CLKF_MIN) ? `VPS_CLKF_MIN :
                       (freq_in > `VPS_CLKF_MAX_HALF) ?
                       `VPS_CLKF_MAX_HALF : freq_in;

   // Mode dependent ceiling on the output clock
   assign fmax = ctrl_r.half ? `VPS_CLKF_MAX_HALF :
                 `VPS_CLKF_MAX_FULL;
   assign freq_eff = (freq_r > fmax) ? fmax : freq_r;

   // Strobe delay no more than 8 ns
   assign strb_clamp = (pwdata_i[3:0] > `VPS_STRB_MAX_NS) ?
                       `VPS_STRB_MAX_NS : pwdata_i[3:0];

   // Only the run bit may change while running
   assign ctrl_wr = locked ? {ctrl_r[4:1], pwdata_i[0]} :
                    pwdata_i[4:0];

   // ********************************************
   // Read data selection
   // ********************************************
   wire logic [31:0] rd_data;

   assign rd_data =
      hit_ctrl ? {27'h0000000, ctrl_r} :
      hit_clkf ? {23'h000000, freq_r} :
      hit_strb ? {28'h0000000, strb_r} :
      hit_init ? {{(32-LW){1'b0}}, init_len_r} :
      hit_main ? {{(32-LW){1'b0}}, main_len_r} :
      hit_wadr ? {{(32-AW){1'b0}}, waddr_r} :
      hit_cond ? cond_r :
      hit_stat ? {29'h00000000, stat_s} :
      32'h00000000;

   // ********************************************
   // APB answer
   // ********************************************

   // Ready one cycle into the access phase
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= setup_ph;
         pslverr_r <= setup_ph & ~mapped;
         if (setup_ph) begin
            prdata_r <= rd_data;
         end
      end
   end

   // ********************************************
   // Control and setup registers
   // ********************************************
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= `VPS_CTRL_RST;
         freq_r <= `VPS_CLKF_RST;
         strb_r <= `VPS_STRB_RST;
      end else begin
         if (wr_ok & hit_ctrl) begin
            ctrl_r <= ctrl_wr;
         end
         if (wr_cfg & hit_clkf) begin
            freq_r <= freq_clamp;
         end
         if (wr_cfg & hit_strb) begin
            strb_r <= strb_clamp;
         end
      end
   end

   // Sequence lengths and wait conditions
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         init_len_r <= '0;
         main_len_r <= '0;
         cond_r <= `VPS_COND_RST;
      end else begin
         if (wr_cfg & hit_init) begin
            init_len_r <= pwdata_i[LW-1:0];
         end
         if (wr_cfg & hit_main) begin
            main_len_r <= pwdata_i[LW-1:0];
         end
         if (wr_cfg & hit_cond) begin
            cond_r <= pwdata_i;
         end
      end
   end

   // Store pointer, steps on every data write accepted while stopped
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         waddr_r <= '0;
      end else if (wr_cfg & hit_wadr) begin
         waddr_r <= pwdata_i[AW-1:0];
      end else if (wr_cfg & hit_wdat) begin
         waddr_r <= waddr_r + AW'(1);
      end
   end

   // Flat vector list loaded by software
   always_ff @(posedge ref_clk_i) begin
      if (wr_cfg & hit_wdat) begin
         mem[waddr_r] <= pwdata_i[`VPS_ENTRY_W-1:0];
      end
   end

   // Clock pod settings and chain start
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_cfg_r <= '0;
         chain_run_r <= 1'b0;
      end else begin
         clk_cfg_r <= {freq_eff, strb_r, ctrl_r.ext_clk,
                       ctrl_r.chain};
         chain_run_r <= ctrl_r.run;
      end
   end

   // ********************************************
   // Crossings into and out of the link domain
   // ********************************************
   logic [5:0] lk_s;
   logic [2:0] stat_r;
   wire logic s_run;
   wire logic [2:0] s_pat;
   wire logic s_arm;
   wire logic s_chain;

   // Run level and target pins into link clock
   vps_sync2 #(.W(6)) u_sync_lk (
      .clk_i(link_clk_i),
      .rst_n_i(rst_n_i),
      .d_i({chain_run_i, arm_in_i, ext_pat_i, ctrl_r.run}),
      .q_o(lk_s)
   );

   // Engine status into register clock
   vps_sync2 #(.W(3)) u_sync_st (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(stat_r),
      .q_o(stat_s)
   );

   assign s_run = lk_s[0];
   assign s_pat = lk_s[3:1];
   assign s_arm = lk_s[4];
   assign s_chain = lk_s[5];

   // ********************************************
   // Playback engine, output clock domain
   // ********************************************
   vps_state_e state_r;
   vps_state_e state_nxt;
   logic [LW-1:0] vcnt_r;
   logic [LW-1:0] vcnt_nxt;
   logic [47:0] data_r;
   logic arm_r;

   wire logic go;
   wire logic [LW-1:0] base;
   wire logic [AW-1:0] ent_idx;
   wire vps_entry_s ent_lo;
   wire vps_entry_s ent_hi;
   wire logic [3:0] cond_hit;
   wire logic stall;
   wire logic active;
   wire logic adv;
   wire logic last;
   wire logic [LW-1:0] seq_len;

   // Master run or shared start from chain
   assign go = ctrl_r.chain ? s_chain : s_run;

   // Vector index to entry index by mode
   assign base = (state_r == VPS_ST_MAIN) ? init_len_r + vcnt_r :
                 vcnt_r;
   assign ent_idx = ctrl_r.half ? base[AW-1:0] :
                    {base[AW-2:0], 1'b0};
   assign ent_lo = mem[ent_idx];
   assign ent_hi = mem[{ent_idx[AW-1:1], 1'b1}];

   // Each condition is an OR over selected patterns
   genvar g;
   generate
      for (g = 0; g < `VPS_NUM_COND; g++) begin : g_cond
         assign cond_hit[g] = cond_r[g*8 + int'(s_pat)];
      end
   endgenerate

   // Wait instructions hold playback
   assign stall = ((ent_lo.op == VPS_OP_WCOND) &
                   ~cond_hit[ent_lo.cond]) |
                  ((ent_lo.op == VPS_OP_WARM) & ~s_arm);
   assign active = (state_r == VPS_ST_INIT) |
                   (state_r == VPS_ST_MAIN);
   assign adv = active & go & ~stall;
   assign seq_len = (state_r == VPS_ST_MAIN) ? main_len_r :
                    init_len_r;
   assign last = vcnt_r == seq_len - LW'(1);

   // Init once, then main once or forever
   always_comb begin
      state_nxt = state_r;
      vcnt_nxt = vcnt_r;
      case (state_r)
         VPS_ST_IDLE: begin
            vcnt_nxt = '0;
            if (go) begin
               if (init_len_r != '0) begin
                  state_nxt = VPS_ST_INIT;
               end else if (main_len_r != '0) begin
                  state_nxt = VPS_ST_MAIN;
               end else begin
                  state_nxt = VPS_ST_DONE;
               end
            end
         end
         VPS_ST_INIT, VPS_ST_MAIN: begin
            if (!go) begin
               state_nxt = VPS_ST_IDLE;
            end else if (adv && last) begin
               vcnt_nxt = '0;
               if (state_r == VPS_ST_INIT && main_len_r != '0) begin
                  state_nxt = VPS_ST_MAIN;
               end else if (state_r == VPS_ST_MAIN && ctrl_r.rep) begin
                  state_nxt = VPS_ST_MAIN;
               end else begin
                  state_nxt = VPS_ST_DONE;
               end
            end else if (adv) begin
               vcnt_nxt = vcnt_r + LW'(1);
            end
         end
         VPS_ST_DONE: begin
            if (!go) begin
               state_nxt = VPS_ST_IDLE;
            end
         end
         default: begin
            state_nxt = VPS_ST_IDLE;
         end
      endcase
   end

   // Engine state registers
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= VPS_ST_IDLE;
         vcnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         vcnt_r <= vcnt_nxt;
      end
   end

   // Vector lanes change only when playback advances
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_r <= 48'h000000000000;
      end else if (adv && ctrl_r.half) begin
         data_r <= {24'h000000, ent_lo.data};
      end else if (adv) begin
         data_r <= {ent_hi.data, ent_lo.data};
      end
   end

   // Arm pulse with its vector, status for software
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arm_r <= 1'b0;
         stat_r <= 3'h0;
      end else begin
         arm_r <= adv & (ent_lo.op == VPS_OP_ARM);
         stat_r <= {state_nxt == VPS_ST_MAIN,
                    active & go & stall,
                    state_nxt != VPS_ST_IDLE};
      end
   end

   // ********************************************
   // Outputs
   // ********************************************
   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign data_o = data_r;
   assign arm_o = arm_r;
   assign chain_run_o = chain_run_r;
   assign clk_cfg_o = clk_cfg_r;

endmodule
`default_nettype wire

// ### logic/vps_sync2.sv
// Two flip-flop level synchroniser, one per bit
`default_nettype none
module vps_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Levels in and out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;

   // First stage read only by the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         q_o <= '0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end

endmodule
`default_nettype wire

// ### verification/vps_sequencer_asserts.sv
// Concurrent port checks for the vector pattern sequencer
`default_nettype none
module vps_sequencer_asserts #(
   parameter int DEPTH = 16
) (
   // Clocks and reset
   input wire logic ref_clk_i,
   input wire logic link_clk_i,
   input wire logic rst_n_i,
   // Register bus
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Vector side and pod settings
   input wire logic [47:0] data_o,
   input wire logic arm_o,
   input wire logic chain_run_o,
   input wire vps_pkg::vps_clkcfg_s clk_cfg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import vps_pkg::*;

   // ********************************************
   // Register bus handshake
   // ********************************************
   a_ready_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      pready_o |=> !pready_o) else $error("ready longer than one cycle");
   a_ready_timed: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      psel_i && $rose(penable_i) |=> pready_o) else $error("ready late");
   a_err_with_ready: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i) pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("error without ready or with data");
   a_unmapped_err: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      psel_i && penable_i && pready_o && paddr_i > 8'h20 |-> pslverr_o)
      else $error("unmapped address accepted");

   // ********************************************
   // Clock pod settings and vector side
   // ********************************************
   a_freq_range: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      $past(rst_n_i) |-> clk_cfg_o.freq_mhz inside {[9'h001:9'h12C]})
      else $error("clock setting out of range");
   a_strobe_cap: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i) clk_cfg_o.strobe_ns <= 4'h8)
      else $error("strobe delay too long");
   a_cfg_frozen: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      chain_run_o && $past(chain_run_o) |-> $stable(clk_cfg_o))
      else $error("pod settings changed in a run");
   a_arm_single: assert property (@(posedge link_clk_i)
      disable iff (!rst_n_i) arm_o |=> !arm_o || $changed(data_o))
      else $error("arm held past its vector");

   // Main scenarios reached
   c_arm: cover property (@(posedge link_clk_i) disable iff (!rst_n_i) arm_o);
   c_err: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) pslverr_o);
   c_run: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(chain_run_o));
endmodule
`default_nettype wire

// ### verification/vps_sequencer_tb.sv
// Self-checking bench for the vector pattern sequencer
`default_nettype none
module vps_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import vps_pkg::*;
   localparam int DEPTH = 16;
   logic ref_clk_i = 1'b0, link_clk_i = 1'b0, rst_n_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic pready_o, pslverr_o, err, arm_o, chain_run_o, arm_in_i, chain_run_i;
   logic [2:0] pat_req = 3'h2, ext_pat_i;
   logic arm_req = 1'b0, run_req = 1'b0;
   logic [47:0] data_o, last_v = 48'h0, arm_v = 48'h0;
   logic [15:0] lfsr = 16'h44B8;
   logic [23:0] v[5];
   vps_clkcfg_s clk_cfg_o;
   logic [47:0] exp_q[$];
   int n_mismatch = 0, checked = 0, seen = 0, n_arm = 0, n;

   // Register clock and unrelated vector clock
   initial forever #25 ref_clk_i = ~ref_clk_i;
   initial begin
      #7;
      forever #24 link_clk_i = ~link_clk_i;
   end

   vps_sequencer #(.DEPTH(DEPTH)) dut (.ref_clk_i, .rst_n_i, .psel_i,
      .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
      .pslverr_o, .link_clk_i, .ext_pat_i, .arm_in_i, .chain_run_i, .data_o,
      .arm_o, .chain_run_o, .clk_cfg_o);
   vps_target_model u_tgt (.link_clk_i, .rst_n_i, .pat_req_i(pat_req),
      .arm_req_i(arm_req), .run_req_i(run_req), .ext_pat_o(ext_pat_i),
      .arm_o(arm_in_i), .chain_run_o(chain_run_i));

   // ********************************************
   // Shared tasks
   // ********************************************
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic timeout();
      n_mismatch++;
      finish_test();
   endtask

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One register transfer, held until ready is seen
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      k = 0;
      // Ready, data and error taken at the edge that ends the access
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) timeout();
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wait_stat(input int b, input logic val);
      int k;
      k = 0;
      do begin
         apb(1'b0, 8'h20, 32'h0);
         k++;
      end while (rd[b] !== val && k < 100);
      if (k >= 100) timeout();
   endtask

   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Vector monitor: each new output vector against the expected list
   always @(negedge link_clk_i) begin
      if (rst_n_i && data_o !== last_v) begin
         last_v = data_o;
         seen++;
         if (exp_q.size() > 0) begin
            check(data_o, exp_q.pop_front());
         end
      end
      if (arm_o === 1'b1) begin
         n_arm++;
         check(data_o, arm_v);
      end
   end

   // ********************************************
   // Main sequence
   // ********************************************
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      check(48'(rd), 48'h64);
      apb(1'b0, 8'h1C, 32'h0);
      check(48'(rd), 48'h0);
      check(48'(clk_cfg_o), 48'h1900);
      apb(1'b0, 8'h40, 32'h0);
      check(48'({err, rd}), 48'h100000000);
      // Clock and strobe limits
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      check(48'(rd), 48'h1);
      apb(1'b1, 8'h04, 32'h190);
      apb(1'b0, 8'h04, 32'h0);
      check(48'(rd), 48'h12C);
      check(48'(clk_cfg_o.freq_mhz), 48'hB4);
      apb(1'b1, 8'h08, 32'hF);
      apb(1'b1, 8'h00, 32'h1A);
      apb(1'b0, 8'h08, 32'h0);
      check(48'(rd), 48'h8);
      check(48'(clk_cfg_o), 48'h4B23);
      // Half mode: two init vectors, main with arm, pattern and arm waits
      apb(1'b1, 8'h1C, 32'h00002804);
      apb(1'b1, 8'h14, 32'h0);
      for (int i = 0; i < 5; i++) begin
         lfsr = nxt(lfsr);
         v[i] = {lfsr, 8'(i)};
         apb(1'b1, 8'h18, {4'h0, 2'(i < 2 ? 0 : i - 1), 2'(i == 3), v[i]});
      end
      arm_v = 48'(v[2]);
      apb(1'b1, 8'h0C, 32'h2);
      apb(1'b1, 8'h10, 32'h3);
      for (int i = 0; i < 11; i++) begin
         exp_q.push_back(48'(v[i < 2 ? i : 2 + (i - 2) % 3]));
      end
      apb(1'b1, 8'h00, 32'h07);
      wait_stat(1, 1'b1);
      check(data_o, 48'(v[2]));
      apb(1'b1, 8'h04, 32'h5);
      apb(1'b0, 8'h04, 32'h0);
      check(48'(rd), 48'h12C);
      pat_req <= 3'h5;
      for (n = 0; n < 400 && seen < 4; n++) @(posedge ref_clk_i);
      if (n >= 400) timeout();
      wait_stat(1, 1'b1);
      repeat (20) @(posedge ref_clk_i);
      check(data_o, 48'(v[3]));
      arm_req <= 1'b1;
      for (n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge ref_clk_i);
      if (n >= 400) timeout();
      check(48'(n_arm >= 3), 48'h1);
      apb(1'b1, 8'h00, 32'h0);
      wait_stat(0, 1'b0);
      // Full mode from the chain start level: one init, one main, one pass
      apb(1'b1, 8'h14, 32'h0);
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         v[i] = {lfsr, 8'(i + 16)};
         apb(1'b1, 8'h18, {8'h0, v[i]});
      end
      exp_q.push_back({v[1], v[0]});
      exp_q.push_back({v[3], v[2]});
      apb(1'b1, 8'h0C, 32'h1);
      apb(1'b1, 8'h10, 32'h1);
      apb(1'b1, 8'h00, 32'h11);
      run_req <= 1'b1;
      for (n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge ref_clk_i);
      if (n >= 400) timeout();
      repeat (20) @(posedge ref_clk_i);
      check(data_o, {v[3], v[2]});
      check(48'(chain_run_o), 48'h1);
      apb(1'b1, 8'h00, 32'h0);
      finish_test();
   end
endmodule

bind vps_sequencer vps_sequencer_asserts #(.DEPTH(DEPTH)) u_chk (.ref_clk_i,
   .link_clk_i, .rst_n_i, .psel_i, .penable_i, .paddr_i, .prdata_o,
   .pready_o, .pslverr_o, .data_o, .arm_o, .chain_run_o, .clk_cfg_o);
`default_nettype wire

// ### verification/vps_target_model.sv
// Target-side model: pattern, arm and chain start levels for the sequencer
`default_nettype none
module vps_target_model (
   // Output clock and reset
   input wire logic link_clk_i,
   input wire logic rst_n_i,
   // Requests from the bench
   input wire logic [2:0] pat_req_i,
   input wire logic arm_req_i,
   input wire logic run_req_i,
   // Levels into the sequencer
   output logic [2:0] ext_pat_o,
   output logic arm_o,
   output logic chain_run_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Levels move just after a vector edge, then hold until asked
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_pat_o <= 3'h0;
         arm_o <= 1'b0;
         chain_run_o <= 1'b0;
      end else begin
         ext_pat_o <= pat_req_i;
         arm_o <= arm_req_i;
         chain_run_o <= run_req_i;
      end
   end
endmodule
`default_nettype wire
